// ### common/cepc_consts.vh
// constants for the endian, reservation and program-counter state block
`ifndef CEPC_CONSTS_VH
`define CEPC_CONSTS_VH

// =====================================================
// register map (byte addresses)
`define CEPC_ADDR_CTRL 8'h00
`define CEPC_ADDR_STATUS 8'h04
`define CEPC_ADDR_PC 8'h08
`define CEPC_ADDR_NEXT_PC 8'h0C
`define CEPC_ADDR_PA_WIDTH 8'h10
`define CEPC_ADDR_DELAYED 8'h14

// =====================================================
// control register fields
`define CEPC_CTRL_RE_BIT 0
`define CEPC_CTRL_USER_BIT 1

// status register fields
`define CEPC_ST_MEM_BE_BIT 0
`define CEPC_ST_REVERSE_BIT 1
`define CEPC_ST_LDST_BE_BIT 2
`define CEPC_ST_RESV_BIT 3
`define CEPC_ST_BRPEND_BIT 4
`define CEPC_ST_DLYPEND_BIT 5

// =====================================================
// program counter sequencing
`define CEPC_PC_RESET 32'h00000000
`define CEPC_INC_SHORT 32'h00000002
`define CEPC_INC_LONG 32'h00000004
`define CEPC_PA_WIDTH_DEF 36

`endif

// ### hw/cepc_reg_xlat.v
// compressed-mode register number translation to full register number
`timescale 1ns/10ps
`default_nettype none

// =====================================================
// short three-bit field to five-bit register number, registered output
module cepc_reg_xlat
(
	input wire core_clk,
	input wire srst,
	input wire [2:0] short_num,
	output reg [4:0] full_num_reg
);
	reg [4:0] full_num_next;

	// short numbers 0 and 1 map to 16 and 17, 2..7 map to themselves
	always @*
	begin
		if (short_num < 3'h2)
			full_num_next = {2'h2, short_num};
		else
			full_num_next = {2'h0, short_num};
	end

	// result registered so the data output comes from a flip-flop
	always @(posedge core_clk)
	begin
		if (srst)
			full_num_reg <= 5'h00;
		else
			full_num_reg <= full_num_next;
	end
endmodule

`default_nettype wire

// ### hw/cepc_state.v
// architectural state: endianness, reservation bit, pc sequencing, delayed writes
//
// What this block does
// - latch memory endianness mode at reset; 0 little, 1 big endian.
// - reverse order flag equals user mode AND the reverse control bit.
// - load/store byte order is memory mode XOR reverse order flag.
// - a load-linked sets the atomic reservation bit.
// - store-conditional tests the reservation bit, then clears it.
// - reservation cleared on conflicting store and on exception return, unless a load-linked retires in the same cycle.
// - without a new pc, advance by 2 for short, 4 for long.
// - taken branch target loads pc during the delay slot instruction.
// - delayed result writes its destination one instruction later.
// - effects of one instruction apply in order; same-time pairs are unordered.
// - physical address width is a parameter, default 36 bits.
// - compressed register fields translate to full register numbers.
// - general register zero always reads as zero.
`timescale 1ns/10ps
`default_nettype none
`include "cepc_consts.vh"

module cepc_state
#(
	parameter PA_WIDTH = `CEPC_PA_WIDTH_DEF
)
(
	input wire core_clk,
	input wire srst,
	// strap sampled while reset is high
	input wire mem_big_endian_strap,
	// AHB-Lite slave
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// instruction retire stream
	input wire instr_valid,
	input wire instr_short,
	input wire instr_load_linked,
	input wire instr_store_cond,
	input wire instr_eret,
	input wire instr_branch_taken,
	input wire [31:0] branch_target,
	input wire instr_jump_now,
	input wire [31:0] jump_target,
	input wire instr_delayed_wr,
	input wire [4:0] delayed_dest,
	input wire [31:0] delayed_data,
	input wire atomic_conflict,
	// register file write/read ports
	input wire rf_we,
	input wire [4:0] rf_waddr,
	input wire [31:0] rf_wdata,
	input wire [4:0] rf_raddr,
	input wire rf_compressed,
	input wire [2:0] rf_short_raddr,
	output reg [31:0] rf_rdata,
	// state outputs
	output wire mem_big_endian_mode,
	output wire reverse_byte_order,
	output wire ldst_big_endian,
	output wire atomic_reservation_bit,
	output wire sc_success,
	output wire [31:0] pc,
	output wire [PA_WIDTH-1:0] phys_addr_mask
);
	// =====================================================
	// state registers
	reg mem_be_reg;
	reg user_reverse_order_bit_reg;
	reg user_mode_reg;
	reg resv_reg;
	reg [31:0] pc_reg;
	reg [31:0] pc_next;
	reg br_pend_reg;
	reg [31:0] br_target_reg;
	reg dly_pend_reg;
	reg [4:0] dly_dest_reg;
	reg [31:0] dly_data_reg;
	reg [31:0] general_register [0:31];
	reg ap_write_reg;
	reg [7:0] ap_addr_reg;
	reg [31:0] rd_mux;
	wire [4:0] xlat_num;
	wire [4:0] rd_idx;
	wire ap_take;
	wire ll_take;
	wire sc_take;
	wire eret_take;
	integer i;
	// width held as a full word so the read mux needs no part-select
	localparam [31:0] PA_WIDTH_WORD = PA_WIDTH;

	// =====================================================
	// physical address width
	// physical address space mask, one bit per implemented address line
	assign phys_addr_mask = {PA_WIDTH{1'b1}};

	// =====================================================
	// endianness
	// strap taken on every clock while reset holds, so the last value wins
	always @(posedge core_clk)
	begin
		if (srst)
			mem_be_reg <= mem_big_endian_strap;
	end

	// reverse order only in user mode; kernel and supervisor keep the strap
	assign mem_big_endian_mode = mem_be_reg;
	assign reverse_byte_order = user_reverse_order_bit_reg & user_mode_reg;
	assign ldst_big_endian = mem_be_reg ^ reverse_byte_order;

	// =====================================================
	// atomic reservation
	// test happens on the current value; clear and set follow in that order
	assign sc_success = instr_valid & instr_store_cond & resv_reg;
	assign atomic_reservation_bit = resv_reg;

	// retire-stream events, each qualified by the retire strobe
	assign ll_take = instr_valid & instr_load_linked;
	assign sc_take = instr_valid & instr_store_cond;
	assign eret_take = instr_valid & instr_eret;

	// a load-linked beats every clear in the same cycle, so a reservation
	// taken together with a conflicting store is kept
	always @(posedge core_clk)
	begin
		if (srst)
			resv_reg <= 1'b0;
		else if (ll_take)
			resv_reg <= 1'b1;
		else if (sc_take | eret_take)
			resv_reg <= 1'b0;
		else if (atomic_conflict)
			resv_reg <= 1'b0;
	end

	// =====================================================
	// program counter sequencing
	// a branch target waits one instruction so the delay slot runs first
	// an immediate jump ranks below a pending branch target
	always @*
	begin
		if (br_pend_reg)
			pc_next = br_target_reg;
		else if (instr_jump_now)
			pc_next = jump_target;
		else if (instr_short)
			pc_next = pc_reg + `CEPC_INC_SHORT;
		else
			pc_next = pc_reg + `CEPC_INC_LONG;
	end

	// pc moves only when an instruction retires; a taken branch sitting in
	// a delay slot is dropped, so software must not place one there
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			pc_reg <= `CEPC_PC_RESET;
			br_pend_reg <= 1'b0;
			br_target_reg <= 32'h00000000;
		end
		else if (instr_valid)
		begin
			pc_reg <= pc_next;
			br_pend_reg <= instr_branch_taken & ~br_pend_reg;
			br_target_reg <= branch_target;
		end
	end

	// pc leaves straight from its register
	assign pc = pc_reg;

	// =====================================================
	// delayed results and register file
	// delayed write lands with the next instruction's own write; the
	// later instruction is applied last since no order is promised
	// destination and data are caught with the instruction that owns them
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			dly_pend_reg <= 1'b0;
			dly_dest_reg <= 5'h00;
			dly_data_reg <= 32'h00000000;
		end
		else if (instr_valid)
		begin
			dly_pend_reg <= instr_delayed_wr;
			dly_dest_reg <= delayed_dest;
			dly_data_reg <= delayed_data;
		end
	end

	// both writes share one process so the port write comes last and wins;
	// register zero may be written, its read is forced to zero instead
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			for (i = 0; i < 32; i = i + 1)
				general_register[i] <= 32'h00000000;
		end
		else
		begin
			if (instr_valid & dly_pend_reg)
				general_register[dly_dest_reg] <= dly_data_reg;
			if (rf_we)
				general_register[rf_waddr] <= rf_wdata;
		end
	end

	// =====================================================
	// register file read port
	// the short field is translated in a flip-flop stage of its own, so the
	// full number and the mode bit are delayed alike before the lookup
	cepc_reg_xlat cepc_reg_xlat_i
	(
		.core_clk(core_clk),
		.srst(srst),
		.short_num(rf_short_raddr),
		.full_num_reg(xlat_num)
	);

	reg compressed_q_reg;
	reg [4:0] raddr_q_reg;
	// first stage: mode bit and full number held one cycle, in step with
	// the translated number coming out of the translation stage
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			compressed_q_reg <= 1'b0;
			raddr_q_reg <= 5'h00;
		end
		else
		begin
			compressed_q_reg <= rf_compressed;
			raddr_q_reg <= rf_raddr;
		end
	end

	// translated number aligned with the registered full number
	assign rd_idx = compressed_q_reg ? xlat_num : raddr_q_reg;

	// second stage: array lookup, register zero forced to zero whatever it holds
	always @(posedge core_clk)
	begin
		if (srst)
			rf_rdata <= 32'h00000000;
		else if (rd_idx == 5'h00)
			rf_rdata <= 32'h00000000;
		else
			rf_rdata <= general_register[rd_idx];
	end

	// =====================================================
	// AHB-Lite register slave, zero wait states, always OKAY
	assign ap_take = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// address phase of a write kept for its data phase; hsize is not
	// checked, every access is taken as a whole word
	// no wait states: only flags, pc values, delayed data and a constant sit behind the bus
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			ap_write_reg <= 1'b0;
			ap_addr_reg <= 8'h00;
		end
		else if (hready)
		begin
			ap_write_reg <= ap_take & hwrite;
			ap_addr_reg <= haddr;
		end
	end

	// control bits written in the data phase
	// a write to any other offset leaves them unchanged
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			user_reverse_order_bit_reg <= 1'b0;
			user_mode_reg <= 1'b0;
		end
		else if (ap_write_reg & (ap_addr_reg == `CEPC_ADDR_CTRL))
		begin
			user_reverse_order_bit_reg <= hwdata[`CEPC_CTRL_RE_BIT];
			user_mode_reg <= hwdata[`CEPC_CTRL_USER_BIT];
		end
	end

	// read data prepared in the address phase, registered for the data phase
	// unmapped offsets read as zero
	always @*
	begin
		rd_mux = 32'h00000000;
		case (haddr)
			`CEPC_ADDR_CTRL:
			begin
				rd_mux[`CEPC_CTRL_RE_BIT] = user_reverse_order_bit_reg;
				rd_mux[`CEPC_CTRL_USER_BIT] = user_mode_reg;
			end
			`CEPC_ADDR_STATUS:
			begin
				rd_mux[`CEPC_ST_MEM_BE_BIT] = mem_be_reg;
				rd_mux[`CEPC_ST_REVERSE_BIT] = reverse_byte_order;
				rd_mux[`CEPC_ST_LDST_BE_BIT] = ldst_big_endian;
				rd_mux[`CEPC_ST_RESV_BIT] = resv_reg;
				rd_mux[`CEPC_ST_BRPEND_BIT] = br_pend_reg;
				rd_mux[`CEPC_ST_DLYPEND_BIT] = dly_pend_reg;
			end
			`CEPC_ADDR_PC: rd_mux = pc_reg;
			`CEPC_ADDR_NEXT_PC: rd_mux = pc_next;
			`CEPC_ADDR_PA_WIDTH: rd_mux = PA_WIDTH_WORD;
			`CEPC_ADDR_DELAYED: rd_mux = dly_data_reg;
			default: rd_mux = 32'h00000000;
		endcase
	end

	// hrdata moves only on a read address phase, so it holds until the
	// next read and a write cycle never disturbs it
	always @(posedge core_clk)
	begin
		if (srst)
			hrdata <= 32'h00000000;
		else if (ap_take & ~hwrite)
			hrdata <= rd_mux;
	end
endmodule

`default_nettype wire

// ### verification/cepc_state_asserts.sv
// assertion checker for the architectural state block
`timescale 1ns/10ps
`default_nettype none
module cepc_state_chk
(
	input wire core_clk,
	input wire srst,
	input wire instr_valid,
	input wire instr_short,
	input wire instr_load_linked,
	input wire instr_store_cond,
	input wire instr_eret,
	input wire instr_branch_taken,
	input wire [31:0] branch_target,
	input wire instr_jump_now,
	input wire [31:0] jump_target,
	input wire atomic_conflict,
	input wire [4:0] rf_raddr,
	input wire rf_compressed,
	input wire [31:0] rf_rdata,
	input wire mem_big_endian_mode,
	input wire reverse_byte_order,
	input wire ldst_big_endian,
	input wire atomic_reservation_bit,
	input wire sc_success,
	input wire [31:0] pc
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// =====================================================
	// branch waiting for its delay slot, kept per retiring instruction
	logic bp_reg;
	logic [31:0] bt_reg;
	always @(posedge core_clk)
	begin
		if (srst)
			bp_reg <= 1'b0;
		else if (instr_valid)
		begin
			bp_reg <= instr_branch_taken;
			bt_reg <= branch_target;
		end
	end
	// =====================================================
	// properties
	AST_MEM_MODE_HELD: assert property (!srst |=> $stable(mem_big_endian_mode))
		else $error("memory endian mode moved outside reset");
	AST_LDST_ORDER: assert property (ldst_big_endian == (mem_big_endian_mode ^ reverse_byte_order))
		else $error("load store byte order wrong");
	AST_LL_SETS: assert property (instr_valid && instr_load_linked |=> atomic_reservation_bit)
		else $error("load linked did not set reservation");
	AST_SC_TEST: assert property (sc_success == (instr_valid && instr_store_cond && atomic_reservation_bit))
		else $error("store conditional outcome wrong");
	AST_SC_CLEARS: assert property (instr_valid && instr_store_cond && !instr_load_linked |=> !atomic_reservation_bit)
		else $error("store conditional left reservation set");
	AST_RESV_DROP: assert property ((instr_valid && instr_eret || atomic_conflict)
		&& !(instr_valid && instr_load_linked) |=> !atomic_reservation_bit)
		else $error("reservation not dropped");
	AST_PC_STEP: assert property (instr_valid && !bp_reg && !instr_jump_now
		|=> pc == $past(pc) + ($past(instr_short) ? 32'h2 : 32'h4))
		else $error("pc step wrong");
	AST_BRANCH_SLOT: assert property (instr_valid && bp_reg && !instr_jump_now |=> pc == $past(bt_reg))
		else $error("branch target not taken after delay slot");
	AST_REG_ZERO: assert property (rf_raddr == 5'h00 && !rf_compressed |-> ##2 rf_rdata == 32'h0)
		else $error("register zero read nonzero");
endmodule
`default_nettype wire

// ### verification/cepc_state_tb_top.sv
// self-checking bench for the architectural state block
`timescale 1ns/10ps
`default_nettype none
module cepc_state_tb_top;
	logic core_clk, srst, mem_big_endian_strap, hsel, hwrite, instr_valid, instr_short, instr_load_linked;
	logic instr_store_cond, instr_eret, instr_branch_taken, instr_jump_now, instr_delayed_wr, atomic_conflict;
	logic rf_we, rf_compressed;
	logic [1:0] htrans;
	logic [2:0] hsize, rf_short_raddr;
	logic [4:0] delayed_dest, rf_waddr, rf_raddr;
	logic [7:0] haddr;
	logic [31:0] hwdata, branch_target, jump_target, delayed_data, rf_wdata, rd;
	logic sc_seen;
	wire hready, hreadyout, hresp, mem_big_endian_mode, reverse_byte_order, ldst_big_endian;
	wire atomic_reservation_bit, sc_success;
	wire [31:0] hrdata, rf_rdata, pc;
	wire [35:0] phys_addr_mask;
	int errors, comparisons;
	// single slave, so its ready is the bus ready
	assign hready = hreadyout;
	cepc_state #(.PA_WIDTH(36)) cepc_state_i
	(
		.core_clk(core_clk), .srst(srst), .mem_big_endian_strap(mem_big_endian_strap),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.instr_valid(instr_valid), .instr_short(instr_short), .instr_load_linked(instr_load_linked),
		.instr_store_cond(instr_store_cond), .instr_eret(instr_eret), .instr_branch_taken(instr_branch_taken),
		.branch_target(branch_target), .instr_jump_now(instr_jump_now), .jump_target(jump_target),
		.instr_delayed_wr(instr_delayed_wr), .delayed_dest(delayed_dest), .delayed_data(delayed_data),
		.atomic_conflict(atomic_conflict), .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
		.rf_raddr(rf_raddr), .rf_compressed(rf_compressed), .rf_short_raddr(rf_short_raddr), .rf_rdata(rf_rdata),
		.mem_big_endian_mode(mem_big_endian_mode), .reverse_byte_order(reverse_byte_order),
		.ldst_big_endian(ldst_big_endian), .atomic_reservation_bit(atomic_reservation_bit),
		.sc_success(sc_success), .pc(pc), .phys_addr_mask(phys_addr_mask)
	);
	// =====================================================
	// tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one whole-word transfer; no wait count assumed, the watchdog cuts a hang
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		@(posedge core_clk);
		while (!hready)
			@(posedge core_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (!hready)
			@(posedge core_clk);
		rd = hrdata;
	endtask
	// flags: delayed, short, load linked, store cond, eret, branch, jump
	task ins(input logic [6:0] f, input logic [31:0] t);
		instr_valid <= 1'b1;
		{instr_delayed_wr, instr_short, instr_load_linked, instr_store_cond, instr_eret, instr_branch_taken,
			instr_jump_now} <= f;
		branch_target <= t;
		jump_target <= t;
		delayed_data <= t;
		// store-conditional outcome looked at mid-cycle, where inputs have settled
		@(negedge core_clk);
		sc_seen = sc_success;
		@(posedge core_clk);
	endtask
	task idle;
		instr_valid <= 1'b0;
		@(posedge core_clk);
	endtask
	task rfr(input logic c, input logic [4:0] a, input logic [2:0] s);
		rf_compressed <= c;
		rf_raddr <= a;
		rf_short_raddr <= s;
		repeat (3) @(posedge core_clk);
		rd = rf_rdata;
		rf_compressed <= 1'b0;
		rf_raddr <= 5'h00;
	endtask
	task rfw(input logic [4:0] a, input logic [31:0] d);
		rf_we <= 1'b1;
		rf_waddr <= a;
		rf_wdata <= d;
		@(posedge core_clk);
		rf_we <= 1'b0;
	endtask
	task end_sim;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// =====================================================
	// clock, watchdog and test sequence
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		#50000;
		errors++;
		end_sim;
	end
	initial
	begin
		{hsel, hwrite, instr_valid, instr_short, instr_load_linked, instr_store_cond, instr_eret, instr_branch_taken,
			instr_jump_now, instr_delayed_wr, atomic_conflict, rf_we, rf_compressed, htrans, rf_short_raddr,
			rf_waddr, rf_raddr, haddr, hwdata, branch_target, jump_target, rf_wdata, delayed_data} = '0;
		hsize = 3'h2;
		delayed_dest = 5'h05;
		srst = 1'b1;
		mem_big_endian_strap = 1'b1;
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		mem_big_endian_strap <= 1'b0;
		@(posedge core_clk);
		chk({31'h0, atomic_reservation_bit}, 32'h0);
		chk({31'h0, mem_big_endian_mode}, 32'h1);
		chk({28'h0, phys_addr_mask[35:32]}, 32'h0000000F);
		ahb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h00000024);
		ahb(1'b1, 8'h00, 32'h1);
		ahb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h00000005);
		ahb(1'b1, 8'h00, 32'h3);
		ahb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h00000003);
		chk({30'h0, reverse_byte_order, ldst_big_endian}, 32'h00000002);
		ahb(1'b1, 8'h00, 32'h2);
		ahb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h00000005);
		ahb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		ins(7'h00, 32'h0);
		ins(7'h20, 32'h0);
		idle;
		chk(pc, 32'h00000006);
		ins(7'h02, 32'h00000100);
		ins(7'h20, 32'h0);
		idle;
		chk(pc, 32'h00000100);
		ins(7'h01, 32'h00000200);
		idle;
		chk(pc, 32'h00000200);
		ins(7'h10, 32'h0);
		idle;
		chk({31'h0, atomic_reservation_bit}, 32'h1);
		ahb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0000000D);
		ins(7'h08, 32'h0);
		chk({31'h0, sc_seen}, 32'h1);
		idle;
		chk({31'h0, atomic_reservation_bit}, 32'h0);
		ins(7'h10, 32'h0);
		ins(7'h04, 32'h0);
		idle;
		chk({31'h0, atomic_reservation_bit}, 32'h0);
		ins(7'h08, 32'h0);
		chk({31'h0, sc_seen}, 32'h0);
		ins(7'h10, 32'h0);
		idle;
		atomic_conflict <= 1'b1;
		@(posedge core_clk);
		atomic_conflict <= 1'b0;
		@(posedge core_clk);
		chk({31'h0, atomic_reservation_bit}, 32'h0);
		// second reset with the strap low and a reservation held
		ins(7'h10, 32'h0);
		srst <= 1'b1;
		instr_valid <= 1'b0;
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		chk({30'h0, mem_big_endian_mode, atomic_reservation_bit}, 32'h0);
		ins(7'h40, 32'h0000CAFE);
		ins(7'h00, 32'h0);
		idle;
		rfr(1'b0, 5'h05, 3'h0);
		chk(rd, 32'h0000CAFE);
		rfw(5'h10, 32'h00001234);
		rfr(1'b1, 5'h00, 3'h0);
		chk(rd, 32'h00001234);
		rfr(1'b1, 5'h00, 3'h5);
		chk(rd, 32'h0000CAFE);
		rfw(5'h11, 32'h00005678);
		rfr(1'b1, 5'h00, 3'h1);
		chk(rd, 32'h00005678);
		rfw(5'h00, 32'h0000FFFF);
		rfr(1'b0, 5'h00, 3'h0);
		chk(rd, 32'h0);
		// delayed write and port write to one register in one cycle
		ins(7'h40, 32'h0000BEEF);
		rf_we <= 1'b1;
		rf_waddr <= 5'h05;
		rf_wdata <= 32'h0000F00D;
		ins(7'h00, 32'h0);
		rf_we <= 1'b0;
		idle;
		rfr(1'b0, 5'h05, 3'h0);
		chk(rd, 32'h0000F00D);
		end_sim;
	end
endmodule
bind cepc_state cepc_state_chk cepc_state_chk_i
(
	.core_clk(core_clk), .srst(srst), .instr_valid(instr_valid), .instr_short(instr_short),
	.instr_load_linked(instr_load_linked), .instr_store_cond(instr_store_cond), .instr_eret(instr_eret),
	.instr_branch_taken(instr_branch_taken), .branch_target(branch_target), .instr_jump_now(instr_jump_now),
	.jump_target(jump_target), .atomic_conflict(atomic_conflict), .rf_raddr(rf_raddr),
	.rf_compressed(rf_compressed), .rf_rdata(rf_rdata), .mem_big_endian_mode(mem_big_endian_mode),
	.reverse_byte_order(reverse_byte_order), .ldst_big_endian(ldst_big_endian),
	.atomic_reservation_bit(atomic_reservation_bit), .sc_success(sc_success), .pc(pc)
);
`default_nettype wire
